// [pkg/uwk_pkg.sv]
// Shared constants for the sleep-wake serial receiver and its transmitter.
// Assumes a single 40 MHz clock on both ends and a 9600 bps line.
package uwk_pkg;

   // ****************************************************
   // Timing
   // ****************************************************
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned BAUD_BPS = 9600;
   // Nearest whole cycle count, so the timing error stays under half a cycle a bit
   localparam int unsigned BIT_CYCLES = (CLK_HZ + BAUD_BPS / 2) / BAUD_BPS;
   localparam int unsigned CNT_W = 13;
   localparam int unsigned DATA_W = 8;

   // ****************************************************
   // Register port and map
   // ****************************************************
   localparam int unsigned REG_AW = 4;
   localparam int unsigned REG_DW = 16;
   localparam logic [3:0] OFS_START = 4'h0; // W: channel start trigger
   localparam logic [3:0] OFS_STOP = 4'h1; // W: channel_stop_trigger
   localparam logic [3:0] OFS_EN_STAT = 4'h2; // R: channel_enable_status
   localparam logic [3:0] OFS_CTRL = 4'h3; // RW: control bits
   localparam logic [3:0] OFS_SLEEP = 4'h4; // W: enter deep sleep
   localparam logic [3:0] OFS_RX_DATA = 4'h5; // R: received byte
   localparam logic [3:0] OFS_IRQ_STAT = 4'h6; // R: sticky events, clear on read
   localparam logic [3:0] OFS_IRQ_MASK = 4'h7; // RW: event enables
   localparam logic [3:0] OFS_PRIO = 4'h8; // RW: interrupt priorities
   localparam logic [3:0] OFS_PWR = 4'h9; // R: power state

   localparam int unsigned CH1_BIT = 1;
   localparam logic [15:0] CH1_TRIG = 16'h0002;

   localparam int unsigned CTRL_CLOCK_GATED_RECEIVE_STATE_EN = 0; // Reception start from deep sleep
   localparam int unsigned CTRL_ERR_SLEEP = 1; // error_action_select: 1 = back to sleep
   localparam int unsigned CTRL_FAST_OSC = 2; // fast_internal_oscillator is the clock
   localparam logic [2:0] CTRL_RST = 3'h0;

   localparam int unsigned IRQ_W = 4;
   localparam int unsigned ST_DONE = 0;
   localparam int unsigned ST_PAR = 1;
   localparam int unsigned ST_FRM = 2;
   localparam int unsigned ST_OVR = 3;
   localparam logic [3:0] MASK_RST = 4'h0;

   // Two bits each: [1:0] transfer end, [3:2] error; 3 is the lowest level
   localparam logic [3:0] PRIO_RST = 4'hF;

   // ****************************************************
   // State types
   // ****************************************************
   typedef enum logic [1:0] {
      PWR_RUN = 2'b00,
      PWR_SLEEP = 2'b01,
      PWR_CLOCK_GATED_RECEIVE_STATE = 2'b10
   } uwk_pwr_e;

   typedef enum logic [2:0] {
      RX_IDLE = 3'b000,
      RX_START = 3'b001,
      RX_DATA = 3'b010,
      RX_PARITY = 3'b011,
      RX_STOP = 3'b100
   } uwk_rx_e;

endpackage : uwk_pkg

// [pkg/uwk_link_if.sv]
// Serial line between the external transmitter and the receiver.
// Assumes both ends share clk_i; the receiver still synchronises the line.
`timescale 1ns/100ps
interface uwk_link_if;
   logic serial_receive_input; // Idle high, start bit low

   modport dev (input serial_receive_input);
   modport src (output serial_receive_input);
endinterface : uwk_link_if

// [design/uwk_rx_dev.sv]
// Receive-only serial channel that stays armed in deep sleep when gated reception and the fast oscillator are both selected.
// Assumes software on the register port and a transmitter on the link.
`timescale 1ns/100ps
module uwk_rx_dev #(
   parameter int unsigned BIT_CYCLES = uwk_pkg::BIT_CYCLES
) (
   input wire logic clk_i, // 40 MHz clock
   input wire logic rst_n_i, // Async reset, active low
   uwk_link_if.dev link, // Serial line in
   input wire logic [uwk_pkg::REG_AW-1:0] reg_addr_i, // Register address
   input wire logic [uwk_pkg::REG_DW-1:0] reg_wdata_i, // Write data
   input wire logic reg_wr_i, // Write strobe
   input wire logic reg_rd_i, // Read strobe
   output logic [uwk_pkg::REG_DW-1:0] reg_rdata_o, // Read data, cycle after strobe
   output logic rx_transfer_end_irq_o, // Unmasked transfer end pending
   output logic rx_error_irq_o, // Unmasked receive error pending
   output logic irq_o, // Any unmasked event pending
   output logic cpu_run_o, // Processor running
   output logic clock_gated_receive_state_o // Gated reception in progress
);

   // ****************************************************
   // Decoding and timing
   // ****************************************************
   localparam logic [uwk_pkg::CNT_W-1:0] FULL_CNT = uwk_pkg::CNT_W'(BIT_CYCLES - 1);
   localparam logic [uwk_pkg::CNT_W-1:0] HALF_CNT = uwk_pkg::CNT_W'(BIT_CYCLES / 2 - 1);

   function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs,
                                input logic strobe);
      hit = strobe && (addr == ofs);
   endfunction : hit

   logic rx_meta_q, rx_sync_q, rx_prev_q;
   logic chan_en_q;
   logic [2:0] ctrl_q;
   logic [uwk_pkg::IRQ_W-1:0] stat_q, mask_q;
   logic [3:0] prio_q;
   logic [uwk_pkg::DATA_W-1:0] shift_q, rx_data_q;
   logic rx_full_q;
   uwk_pkg::uwk_rx_e rx_st_q;
   logic [uwk_pkg::CNT_W-1:0] cnt_q;
   logic [2:0] bit_q;
   logic par_q;
   logic fr_done_q, fr_par_q, fr_frm_q, fr_ovr_q;
   uwk_pkg::uwk_pwr_e pwr_q, pwr_d;
   logic fall, clock_gated_receive_state_ok, rx_active, fr_err, discard;
   logic [uwk_pkg::IRQ_W-1:0] stat_set;

   // ****************************************************
   // Line input
   // ****************************************************
   // Two flops before use; the line is asynchronous to clk_i
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_meta_q <= 1'b1;
         rx_sync_q <= 1'b1;
         rx_prev_q <= 1'b1;
      end else begin
         rx_meta_q <= link.serial_receive_input;
         rx_sync_q <= rx_meta_q;
         rx_prev_q <= rx_sync_q;
      end
   end

   // Start edge is high to low on the synchronised line
   assign fall = rx_prev_q && !rx_sync_q;
   assign clock_gated_receive_state_ok = ctrl_q[uwk_pkg::CTRL_CLOCK_GATED_RECEIVE_STATE_EN] && ctrl_q[uwk_pkg::CTRL_FAST_OSC];
   assign rx_active = chan_en_q && (pwr_q != uwk_pkg::PWR_SLEEP || clock_gated_receive_state_ok);
   assign fr_err = fr_par_q || fr_frm_q || fr_ovr_q;
   // Gated error with sleep selected drops the frame silently
   assign discard = (pwr_q == uwk_pkg::PWR_CLOCK_GATED_RECEIVE_STATE) && fr_err &&
                    ctrl_q[uwk_pkg::CTRL_ERR_SLEEP];

   // ****************************************************
   // Frame receiver
   // ****************************************************
   // Samples at mid-bit; a start bit gone high at mid-bit is a glitch
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_st_q <= uwk_pkg::RX_IDLE;
         cnt_q <= '0;
         bit_q <= '0;
         shift_q <= '0;
         par_q <= 1'b0;
         fr_done_q <= 1'b0;
         fr_par_q <= 1'b0;
         fr_frm_q <= 1'b0;
         fr_ovr_q <= 1'b0;
      end else begin
         fr_done_q <= 1'b0;
         cnt_q <= cnt_q + 1'b1;
         if (!chan_en_q) begin
            rx_st_q <= uwk_pkg::RX_IDLE;
         end else begin
            unique case (rx_st_q)
               uwk_pkg::RX_IDLE: begin
                  cnt_q <= '0;
                  if (rx_active && fall) begin
                     rx_st_q <= uwk_pkg::RX_START;
                  end
               end
               uwk_pkg::RX_START: begin
                  if (cnt_q == HALF_CNT) begin
                     cnt_q <= '0;
                     bit_q <= '0;
                     rx_st_q <= rx_sync_q ? uwk_pkg::RX_IDLE : uwk_pkg::RX_DATA;
                  end
               end
               uwk_pkg::RX_DATA: begin
                  if (cnt_q == FULL_CNT) begin
                     cnt_q <= '0;
                     shift_q <= {rx_sync_q, shift_q[uwk_pkg::DATA_W-1:1]};
                     bit_q <= bit_q + 1'b1;
                     if (bit_q == 3'h7) begin
                        rx_st_q <= uwk_pkg::RX_PARITY;
                     end
                  end
               end
               uwk_pkg::RX_PARITY: begin
                  if (cnt_q == FULL_CNT) begin
                     cnt_q <= '0;
                     par_q <= rx_sync_q;
                     rx_st_q <= uwk_pkg::RX_STOP;
                  end
               end
               uwk_pkg::RX_STOP: begin
                  if (cnt_q == FULL_CNT) begin
                     rx_st_q <= uwk_pkg::RX_IDLE;
                     fr_done_q <= 1'b1;
                     fr_par_q <= ^{shift_q, par_q};
                     fr_frm_q <= !rx_sync_q;
                     fr_ovr_q <= rx_full_q;
                  end
               end
               default: begin
                  rx_st_q <= uwk_pkg::RX_IDLE;
               end
            endcase
         end
      end
   end

   // ****************************************************
   // Power state
   // ****************************************************
   always_comb begin
      pwr_d = pwr_q;
      unique case (pwr_q)
         uwk_pkg::PWR_RUN: begin
            if (hit(reg_addr_i, uwk_pkg::OFS_SLEEP, reg_wr_i)) begin
               pwr_d = uwk_pkg::PWR_SLEEP;
            end
         end
         uwk_pkg::PWR_SLEEP: begin
            if (rx_st_q == uwk_pkg::RX_IDLE && rx_active && fall) begin
               pwr_d = uwk_pkg::PWR_CLOCK_GATED_RECEIVE_STATE;
            end
         end
         uwk_pkg::PWR_CLOCK_GATED_RECEIVE_STATE: begin
            if (fr_done_q) begin
               // Good frame or error with interrupt selected both wake the processor
               pwr_d = discard ? uwk_pkg::PWR_SLEEP : uwk_pkg::PWR_RUN;
            end else if (rx_st_q == uwk_pkg::RX_IDLE) begin
               pwr_d = uwk_pkg::PWR_SLEEP;
            end
         end
         default: begin
            pwr_d = uwk_pkg::PWR_RUN;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pwr_q <= uwk_pkg::PWR_RUN;
         cpu_run_o <= 1'b1;
         clock_gated_receive_state_o <= 1'b0;
      end else begin
         pwr_q <= pwr_d;
         cpu_run_o <= (pwr_d == uwk_pkg::PWR_RUN);
         clock_gated_receive_state_o <= (pwr_d == uwk_pkg::PWR_CLOCK_GATED_RECEIVE_STATE);
      end
   end

   // ****************************************************
   // Software registers
   // ****************************************************
   // Channel enable from start and stop triggers
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         chan_en_q <= 1'b0;
      end else if (hit(reg_addr_i, uwk_pkg::OFS_START, reg_wr_i) &&
                   reg_wdata_i[uwk_pkg::CH1_BIT]) begin
         chan_en_q <= 1'b1;
      end else if (hit(reg_addr_i, uwk_pkg::OFS_STOP, reg_wr_i) &&
                   reg_wdata_i[uwk_pkg::CH1_BIT]) begin
         chan_en_q <= 1'b0;
      end
   end

   // Control, mask and priority
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_q <= uwk_pkg::CTRL_RST;
         mask_q <= uwk_pkg::MASK_RST;
         prio_q <= uwk_pkg::PRIO_RST;
      end else begin
         if (hit(reg_addr_i, uwk_pkg::OFS_CTRL, reg_wr_i)) begin
            ctrl_q <= reg_wdata_i[2:0];
         end
         if (hit(reg_addr_i, uwk_pkg::OFS_IRQ_MASK, reg_wr_i)) begin
            mask_q <= reg_wdata_i[uwk_pkg::IRQ_W-1:0];
         end
         if (hit(reg_addr_i, uwk_pkg::OFS_PRIO, reg_wr_i)) begin
            prio_q <= reg_wdata_i[3:0];
         end
      end
   end

   // Received byte; an overrun keeps the unread byte
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_data_q <= '0;
         rx_full_q <= 1'b0;
      end else if (fr_done_q && !discard && !fr_ovr_q) begin
         rx_data_q <= shift_q;
         rx_full_q <= 1'b1;
      end else if (hit(reg_addr_i, uwk_pkg::OFS_RX_DATA, reg_rd_i)) begin
         rx_full_q <= 1'b0;
      end
   end

   // Sticky events; a new event beats a clearing read
   always_comb begin
      stat_set = '0;
      if (fr_done_q && !discard) begin
         stat_set[uwk_pkg::ST_DONE] = !fr_err;
         stat_set[uwk_pkg::ST_PAR] = fr_par_q;
         stat_set[uwk_pkg::ST_FRM] = fr_frm_q;
         stat_set[uwk_pkg::ST_OVR] = fr_ovr_q;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stat_q <= '0;
      end else if (hit(reg_addr_i, uwk_pkg::OFS_IRQ_STAT, reg_rd_i)) begin
         stat_q <= stat_set;
      end else begin
         stat_q <= stat_q | stat_set;
      end
   end

   // Interrupt outputs, registered from status and mask
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_transfer_end_irq_o <= 1'b0;
         rx_error_irq_o <= 1'b0;
         irq_o <= 1'b0;
      end else begin
         rx_transfer_end_irq_o <= stat_q[uwk_pkg::ST_DONE] && mask_q[uwk_pkg::ST_DONE];
         rx_error_irq_o <= |(stat_q[3:1] & mask_q[3:1]);
         irq_o <= |(stat_q & mask_q);
      end
   end

   // Read data for one cycle after the strobe, zero otherwise
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= '0;
      end else begin
         reg_rdata_o <= '0;
         if (reg_rd_i) begin
            unique case (reg_addr_i)
               uwk_pkg::OFS_EN_STAT: reg_rdata_o <= {14'h0, chan_en_q, 1'b0};
               uwk_pkg::OFS_CTRL: reg_rdata_o <= {13'h0, ctrl_q};
               uwk_pkg::OFS_RX_DATA: reg_rdata_o <= {8'h00, rx_data_q};
               uwk_pkg::OFS_IRQ_STAT: reg_rdata_o <= {12'h000, stat_q};
               uwk_pkg::OFS_IRQ_MASK: reg_rdata_o <= {12'h000, mask_q};
               uwk_pkg::OFS_PRIO: reg_rdata_o <= {12'h000, prio_q};
               uwk_pkg::OFS_PWR: reg_rdata_o <= {14'h0, pwr_q};
               default: reg_rdata_o <= '0;
            endcase
         end
      end
   end

   // No transmitter here: the channel only listens

endmodule : uwk_rx_dev

// [design/uwk_tx_src.sv]
// External asynchronous transmitter driving the receive line.
// Assumes the same 40 MHz clock; frames are 8 data, even parity, 1 stop.
`timescale 1ns/100ps
module uwk_tx_src #(
   parameter int unsigned BIT_CYCLES = uwk_pkg::BIT_CYCLES
) (
   input wire logic clk_i, // 40 MHz clock
   input wire logic rst_n_i, // Async reset, active low
   uwk_link_if.src link, // Serial line out
   input wire logic send_i, // Start a frame, taken when idle
   input wire logic [uwk_pkg::DATA_W-1:0] data_i, // Byte to send
   input wire logic bad_parity_i, // Send odd parity instead
   input wire logic bad_stop_i, // Send a low stop bit
   output logic busy_o // Frame in progress
);

   // ****************************************************
   // Frame shifter
   // ****************************************************
   localparam logic [uwk_pkg::CNT_W-1:0] FULL_CNT = uwk_pkg::CNT_W'(BIT_CYCLES - 1);
   localparam logic [3:0] LAST_BIT = 4'hA;

   logic [10:0] frame_q;
   logic [uwk_pkg::CNT_W-1:0] cnt_q;
   logic [3:0] bit_q;
   logic line_q;

   assign link.serial_receive_input = line_q;

   // Start low, data LSB first, even parity, one stop; idle high
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         frame_q <= '1;
         cnt_q <= '0;
         bit_q <= '0;
         busy_o <= 1'b0;
         line_q <= 1'b1;
      end else if (!busy_o) begin
         cnt_q <= '0;
         bit_q <= '0;
         if (send_i) begin
            frame_q <= {!bad_stop_i, ^data_i ^ bad_parity_i, data_i, 1'b0};
            busy_o <= 1'b1;
            line_q <= 1'b0;
         end
      end else if (cnt_q == FULL_CNT) begin
         cnt_q <= '0;
         bit_q <= bit_q + 1'b1;
         if (bit_q == LAST_BIT) begin
            busy_o <= 1'b0;
            line_q <= 1'b1;
         end else begin
            line_q <= frame_q[bit_q + 1'b1];
         end
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

endmodule : uwk_tx_src

// [test/uwk_link_sva.sv]
// Checker for the serial line, the transmitter handshake and the receiver outputs.
// Assumes one clock domain; instantiated beside the link interface by the bench.
`timescale 1ns/100ps
module uwk_link_sva #(
   parameter int unsigned BIT_CYCLES = uwk_pkg::BIT_CYCLES
) (
   input wire logic clk_i, // Clock
   input wire logic rst_n_i, // Async reset, active low
   input wire logic serial_receive_input, // Serial line
   input wire logic send_i, // Transmitter start request
   input wire logic busy_o, // Transmitter frame in progress
   input wire logic reg_rd_i, // Read strobe
   input wire logic [uwk_pkg::REG_DW-1:0] reg_rdata_o, // Read data
   input wire logic irq_o, // Any unmasked event
   input wire logic rx_transfer_end_irq_o, // Byte done event
   input wire logic rx_error_irq_o, // Receive error event
   input wire logic cpu_run_o, // Processor running
   input wire logic clock_gated_receive_state_o // Gated reception
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   // ************************************************
   // Helper logic
   // ************************************************
   logic [15:0] busy_cnt_q;

   // Cycles spent in the current frame; a counter avoids a long repetition
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy_cnt_q <= 16'h0000;
      end else if (busy_o) begin
         busy_cnt_q <= busy_cnt_q + 16'h0001;
      end else begin
         busy_cnt_q <= 16'h0000;
      end
   end

   // ************************************************
   // Assertions
   // ************************************************
   a_line_idle_high: assert property (!busy_o |-> serial_receive_input)
      else $error("line low outside a frame");
   a_start_bit_low: assert property ($rose(busy_o) |-> !serial_receive_input [*8])
      else $error("start bit not low");
   a_frame_eleven_bits: assert property ($fell(busy_o) |-> busy_cnt_q == 16'(11 * BIT_CYCLES))
      else $error("frame length wrong");
   // Line may only move on a bit boundary
   a_bit_boundary: assert property (busy_o && $changed(serial_receive_input)
      |-> (32'(busy_cnt_q) % BIT_CYCLES) == 0)
      else $error("line changed inside a bit");
   a_send_taken: assert property (send_i && !busy_o |=> busy_o)
      else $error("idle send not taken");
   a_gated_no_cpu: assert property (clock_gated_receive_state_o |-> !cpu_run_o)
      else $error("processor runs during gated reception");
   a_gated_bounded: assert property ($rose(clock_gated_receive_state_o)
      |-> ##[1:220] !clock_gated_receive_state_o)
      else $error("gated reception never ends");
   a_wake_with_irq: assert property ($rose(cpu_run_o) |-> ##[1:2] irq_o)
      else $error("wake without interrupt");
   a_irq_is_or: assert property (irq_o == (rx_transfer_end_irq_o || rx_error_irq_o))
      else $error("irq not the or of the events");
   a_rdata_quiet: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
      else $error("read data outside read slot");
endmodule : uwk_link_sva

// [test/test_uart_rx_wake_from_sleep.sv]
// Self-checking bench: transmitter and receiver joined by the link interface.
// Assumes BIT_CYCLES shortened to 16, so one frame lasts 176 clock cycles.
`timescale 1ns/100ps
module test_uart_rx_wake_from_sleep;
   localparam int unsigned BC = 16;
   typedef struct packed {
      logic [7:0] data;
      logic bp;
      logic bs;
      logic rd;
      logic [15:0] stat;
      logic [15:0] dat;
   } uwk_row_s;
   // Overrun pair after four clean bytes; a parity-error byte is still stored, so it is read back
   uwk_row_s rows [8] = '{
      '{8'h00, 1'b0, 1'b0, 1'b1, 16'h0001, 16'h0000},
      '{8'hFF, 1'b0, 1'b0, 1'b1, 16'h0001, 16'h00FF},
      '{8'h01, 1'b0, 1'b0, 1'b1, 16'h0001, 16'h0001},
      '{8'h80, 1'b0, 1'b0, 1'b1, 16'h0001, 16'h0080},
      '{8'h5A, 1'b0, 1'b0, 1'b0, 16'h0001, 16'h0000},
      '{8'hC3, 1'b0, 1'b0, 1'b1, 16'h0008, 16'h005A},
      '{8'hA5, 1'b1, 1'b0, 1'b1, 16'h0002, 16'h00A5},
      '{8'h3C, 1'b0, 1'b1, 1'b0, 16'h0004, 16'h0000}};
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [3:0] reg_addr_i = 4'h0;
   logic [15:0] reg_wdata_i = 16'h0000;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [15:0] reg_rdata_o;
   logic rx_transfer_end_irq_o;
   logic rx_error_irq_o;
   logic irq_o;
   logic cpu_run_o;
   logic clock_gated_receive_state_o;
   logic send_i = 1'b0;
   logic [7:0] data_i = 8'h00;
   logic bad_parity_i = 1'b0;
   logic bad_stop_i = 1'b0;
   logic busy_o;
   int err_count = 0;
   int n_compared = 0;
   int cycles = 0;

   // ************************************************
   // Clock, design and checker
   // ************************************************
   always #12.5 clk_i = ~clk_i;
   uwk_link_if u_uwk_link_if ();
   uwk_tx_src #(.BIT_CYCLES(BC)) u_uwk_tx_src (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .link(u_uwk_link_if), .send_i(send_i), .data_i(data_i), .bad_parity_i(bad_parity_i),
      .bad_stop_i(bad_stop_i), .busy_o(busy_o));
   uwk_rx_dev #(.BIT_CYCLES(BC)) u_uwk_rx_dev (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .link(u_uwk_link_if), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .rx_transfer_end_irq_o(rx_transfer_end_irq_o), .rx_error_irq_o(rx_error_irq_o),
      .irq_o(irq_o), .cpu_run_o(cpu_run_o),
      .clock_gated_receive_state_o(clock_gated_receive_state_o));
   uwk_link_sva #(.BIT_CYCLES(BC)) u_uwk_link_sva (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .serial_receive_input(u_uwk_link_if.serial_receive_input), .send_i(send_i),
      .busy_o(busy_o), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o),
      .rx_transfer_end_irq_o(rx_transfer_end_irq_o), .rx_error_irq_o(rx_error_irq_o),
      .cpu_run_o(cpu_run_o), .clock_gated_receive_state_o(clock_gated_receive_state_o));

   // ************************************************
   // Tasks
   // ************************************************
   task automatic end_sim;
      if (err_count == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_sim

   task automatic chk1(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask : chk1

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask : wr

   // Register read and compare; data is valid only in the slot after the strobe
   task automatic rdc(input logic [3:0] a, input logic [15:0] exp, input logic cmp = 1'b1);
      @(posedge clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1;
      if (cmp) begin
         n_compared++;
         if (reg_rdata_o !== exp) begin
            err_count++;
            $display("mismatch at %0t: reg %h read %h expected %h", $time, a, reg_rdata_o, exp);
         end
      end
   endtask : rdc

   // Send one frame and wait, bounded, until the line is idle again
   task automatic frame(input logic [7:0] d, input logic bp, input logic bs, input int mid = 0);
      int n;
      @(posedge clk_i);
      send_i <= 1'b1;
      data_i <= d;
      bad_parity_i <= bp;
      bad_stop_i <= bs;
      @(posedge clk_i);
      send_i <= 1'b0;
      if (mid > 0) begin
         repeat (mid) @(posedge clk_i);
         #1;
         chk1(clock_gated_receive_state_o, 1'b1);
         chk1(cpu_run_o, 1'b0);
      end
      n = 0;
      #1;
      while (busy_o !== 1'b0 && n < 400) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      if (n >= 400) begin
         err_count++;
         $display("mismatch at %0t: transmitter stuck busy", $time);
      end
      repeat (4) @(posedge clk_i);
      #1;
   endtask : frame

   // Hang guard, well above the expected run of about 2700 cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 12000) begin
         err_count++;
         $display("mismatch at %0t: run did not finish", $time);
         end_sim();
      end
   end

   // ************************************************
   // Main sequence
   // ************************************************
   initial begin
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      wr(uwk_pkg::OFS_START, uwk_pkg::CH1_TRIG);
      rdc(uwk_pkg::OFS_EN_STAT, 16'h0002);
      wr(uwk_pkg::OFS_IRQ_MASK, 16'h000F);
      // Frames received while running
      foreach (rows[i]) begin
         frame(rows[i].data, rows[i].bp, rows[i].bs);
         chk1(irq_o, 1'b1);
         chk1(rx_error_irq_o, |rows[i].stat[3:1]);
         rdc(uwk_pkg::OFS_IRQ_STAT, rows[i].stat);
         if (rows[i].rd) begin
            rdc(uwk_pkg::OFS_RX_DATA, rows[i].dat);
         end
      end
      rdc(uwk_pkg::OFS_RX_DATA, 16'h0000, 1'b0);
      // Stop trigger needs bit 1; a stopped channel ignores the line
      wr(uwk_pkg::OFS_STOP, 16'h0001);
      rdc(uwk_pkg::OFS_EN_STAT, 16'h0002);
      wr(uwk_pkg::OFS_STOP, uwk_pkg::CH1_TRIG);
      rdc(uwk_pkg::OFS_EN_STAT, 16'h0000);
      frame(8'h11, 1'b0, 1'b0);
      rdc(uwk_pkg::OFS_IRQ_STAT, 16'h0000);
      rdc(4'hF, 16'h0000);
      // Armed sleep: bad frames go back to sleep, a good one wakes
      wr(uwk_pkg::OFS_START, uwk_pkg::CH1_TRIG);
      wr(uwk_pkg::OFS_IRQ_MASK, 16'h0001);
      wr(uwk_pkg::OFS_CTRL, 16'h0007);
      wr(uwk_pkg::OFS_SLEEP, 16'h0000);
      frame(8'h66, 1'b1, 1'b0);
      chk1(cpu_run_o, 1'b0);
      chk1(irq_o, 1'b0);
      rdc(uwk_pkg::OFS_PWR, 16'h0001);
      frame(8'h67, 1'b0, 1'b1);
      chk1(cpu_run_o, 1'b0);
      frame(8'hE7, 1'b0, 1'b0, 5 * BC);
      chk1(cpu_run_o, 1'b1);
      chk1(clock_gated_receive_state_o, 1'b0);
      chk1(rx_transfer_end_irq_o, 1'b1);
      rdc(uwk_pkg::OFS_RX_DATA, 16'h00E7);
      rdc(uwk_pkg::OFS_IRQ_STAT, 16'h0001);
      // Error action set to interrupt: a bad gated frame wakes with error
      wr(uwk_pkg::OFS_IRQ_MASK, 16'h000F);
      wr(uwk_pkg::OFS_CTRL, 16'h0005);
      wr(uwk_pkg::OFS_SLEEP, 16'h0000);
      frame(8'h42, 1'b1, 1'b0);
      chk1(cpu_run_o, 1'b1);
      chk1(rx_error_irq_o, 1'b1);
      rdc(uwk_pkg::OFS_IRQ_STAT, 16'h0002);
      rdc(uwk_pkg::OFS_PRIO, 16'h000F);
      wr(uwk_pkg::OFS_PRIO, 16'h0006);
      rdc(uwk_pkg::OFS_PRIO, 16'h0006);
      // Fast oscillator not selected: sleep ignores the line
      wr(uwk_pkg::OFS_CTRL, 16'h0003);
      wr(uwk_pkg::OFS_SLEEP, 16'h0000);
      frame(8'h24, 1'b0, 1'b0);
      chk1(clock_gated_receive_state_o, 1'b0);
      chk1(cpu_run_o, 1'b0);
      // Reset in mid-run brings back the idle values
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      #1;
      chk1(cpu_run_o, 1'b1);
      rdc(uwk_pkg::OFS_CTRL, 16'h0000);
      rdc(uwk_pkg::OFS_IRQ_MASK, 16'h0000);
      rdc(uwk_pkg::OFS_PRIO, 16'h000F);
      rdc(uwk_pkg::OFS_EN_STAT, 16'h0000);
      rdc(uwk_pkg::OFS_PWR, 16'h0000);
      end_sim();
   end
endmodule : test_uart_rx_wake_from_sleep
